// [hw/stack_branch_pkg.sv]
/*
  Shared constants and carriers for the compact stack, block-transfer and branch executor.
  Assumes a 16-bit instruction word from fetch and a single-word memory port with fixed latency.
*/
`default_nettype none
package stack_branch_pkg;

  // Opcode field positions in the compact encoding
  localparam int OP_LOAD_BIT = 11;
  localparam int OP_EXTRA_BIT = 8;
  localparam int OP_BASE_LSB = 8;
  localparam int OP_COND_LSB = 8;

  localparam logic [3:0] MATCH_STACK_HI = 4'hB;
  localparam logic [1:0] MATCH_STACK_MID = 2'h2;
  localparam logic [3:0] MATCH_MULTI_HI = 4'hC;
  localparam logic [3:0] MATCH_COND_HI = 4'hD;

  localparam logic [3:0] COND_UNDEFINED = 4'hE;
  localparam logic [3:0] COND_SOFT_INT = 4'hF;

  localparam logic [31:0] PREFETCH_BYTES = 32'h0000_0004;
  localparam logic [31:0] HALFWORD_BYTES = 32'h0000_0002;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] SOFT_INT_VECTOR = 32'h0000_0008;

  localparam logic [4:0] MODE_SUPERVISOR = 5'h13;
  localparam int FLAG_N = 31;
  localparam int FLAG_Z = 30;
  localparam int FLAG_C = 29;
  localparam int FLAG_V = 28;
  localparam int STATE_BIT = 5;

  // Wide-format internal cycle figures: one extra cycle for base update, two for refill on branch
  localparam logic [1:0] REFILL_CYCLES = 2'h2;

  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] RESET_STATUS = 32'h0000_00D3;

  typedef enum logic [1:0] {
    OUT_NONE,
    OUT_BRANCH,
    OUT_SOFT_INT,
    OUT_UNDEF
  } outcome_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [31:0] data;
  } reg_wr_t;

endpackage
`default_nettype wire

// [hw/cond_eval.sv]
/*
  Condition evaluator for the compact conditional branch.
  Assumes flags from the current status word, sampled in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module cond_eval (
  // Condition and flags
  input wire logic [3:0] cond,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_c,
  input wire logic flag_v,
  // Decision
  output logic pass
);
  logic base;
  always_comb begin
    case (cond[3:1])
      3'h0: base = flag_z;
      3'h1: base = flag_c;
      3'h2: base = flag_n;
      3'h3: base = flag_v;
      3'h4: base = flag_c & ~flag_z;
      3'h5: base = (flag_n == flag_v);
      3'h6: base = ~flag_z & (flag_n == flag_v);
      default: base = 1'b0;
    endcase
    // Odd codes are the exact complement of the even ones
    pass = base ^ cond[0];
  end
endmodule
`default_nettype wire

// [hw/stack_branch_exec.sv]
/*
  Executor for the compact push/pop, multiple load/store and conditional branch formats.
  Assumes fetch holds instr stable while busy is high, and memory answers a read while its request stands.
*/
// Operation
// - Stack transfers use only low registers 0-7, plus link on push, PC on pop.
// - Stack is full descending: pointer at last used word, pushes grow downward.
// - Push without link stores list decrement-before, writes back lowered pointer.
// - Push with link stores list plus link register; empty list allowed.
// - Pop without PC loads list increment-after, writes back raised pointer.
// - Pop with PC loads list then PC, updates pointer, and branches.
// - Multiple transfer uses low registers only, for list and base.
// - Multiple store writes list at successive words from base, writes back.
// - Multiple load reads list from successive words from base, writes back unless the base is in the list.
// - Branch decided on status flags, target relative to instruction address plus 4.
// - Code 0000 branches on Z set, 0001 on Z clear.
// - Code 0010 branches on C set, 0011 on C clear.
// - Code 0100 branches on N set, 0101 on N clear.
// - Code 0110 branches on V set, 0111 on V clear.
// - Code 1000 needs C set, Z clear; 1001 C clear or Z set.
// - Code 1010 needs N equal V; 1011 N differs from V.
// - Code 1100 Z clear and N equal V; 1101 the opposite.
// - Offset is signed halfwords, sign-extended and doubled to a byte displacement.
// - Code 1111 decodes as the software interrupt, not a branch.
// - Soft interrupt saves next address and status, jumps to 0x8, supervisor mode.
`timescale 1ns/1ns
`default_nettype none
module stack_branch_exec #(
  parameter int NUM_LOW = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction from fetch
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  // Register file read view
  input wire logic [31:0] low_regs [NUM_LOW],
  input wire logic [31:0] stack_ptr,
  input wire logic [31:0] return_link_register,
  input wire logic [31:0] current_status_word,
  // Memory port
  output stack_branch_pkg::mem_req_t mem_req,
  input wire logic [31:0] mem_rdata,
  // Register file write and control results
  output stack_branch_pkg::reg_wr_t reg_wr,
  output logic busy,
  output logic done,
  output logic pc_load,
  output logic [31:0] pc_value,
  output logic status_load,
  output logic [31:0] status_value,
  output logic saved_status_load,
  output logic [31:0] saved_status_value,
  output logic undefined_instr
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_LOAD_WAIT,
    ST_WRITEBACK,
    ST_REFILL,
    ST_FINISH
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] pending;
    logic with_extra;
    logic extra_done;
    logic is_load;
    logic is_stack;
    logic [2:0] base_idx;
    logic base_hit;
    logic [31:0] addr;
    logic [31:0] final_base;
    logic [3:0] load_dst;
    logic [1:0] refill;
    stack_branch_pkg::mem_req_t mem;
    stack_branch_pkg::reg_wr_t wr;
    logic done;
    logic pc_load;
    logic [31:0] pc_value;
    logic status_load;
    logic [31:0] status_value;
    logic saved_load;
    logic [31:0] saved_value;
    logic undef;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // Decode
  logic is_stack_fmt;
  logic is_multi_fmt;
  logic is_cond_fmt;
  logic ld_bit;
  logic ex_bit;
  logic [7:0] rlist;
  logic [3:0] cond_code;
  logic cond_pass;
  logic [31:0] branch_disp;
  logic [5:0] count;
  logic [2:0] first_idx;
  logic has_first;
  logic base_listed;

  // Field positions fixed by the compact encoding
  assign is_stack_fmt = (instr[15:12] == stack_branch_pkg::MATCH_STACK_HI)
      && (instr[10:9] == stack_branch_pkg::MATCH_STACK_MID);
  assign is_multi_fmt = (instr[15:12] == stack_branch_pkg::MATCH_MULTI_HI);
  assign is_cond_fmt = (instr[15:12] == stack_branch_pkg::MATCH_COND_HI);
  assign ld_bit = instr[stack_branch_pkg::OP_LOAD_BIT];
  assign ex_bit = instr[stack_branch_pkg::OP_EXTRA_BIT];
  assign rlist = instr[7:0];
  assign cond_code = instr[stack_branch_pkg::OP_COND_LSB +: 4];
  // Base named in its own list; only the multiple load cares
  assign base_listed = rlist[instr[stack_branch_pkg::OP_BASE_LSB +: 3]];

  // Signed halfword count doubled into a byte displacement, bit 0 zero
  assign branch_disp = {{23{instr[7]}}, instr[7:0], 1'b0};

  // Per-code flag tests live in the evaluator
  cond_eval u_cond (
    .cond(cond_code),
    .flag_n(current_status_word[stack_branch_pkg::FLAG_N]),
    .flag_z(current_status_word[stack_branch_pkg::FLAG_Z]),
    .flag_c(current_status_word[stack_branch_pkg::FLAG_C]),
    .flag_v(current_status_word[stack_branch_pkg::FLAG_V]),
    .pass(cond_pass)
  );

  // Population count of the low list plus the extra register
  always_comb begin
    count = 6'h00;
    for (int i = 0; i < 8; i++) begin
      count = count + {5'h00, rlist[i]};
    end
    if (is_stack_fmt && ex_bit) begin
      count = count + 6'h01;
    end
  end

  // Lowest pending register, transfers go lowest register to lowest address
  always_comb begin
    first_idx = 3'h0;
    has_first = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (state_r.pending[i]) begin
        first_idx = i[2:0];
        has_first = 1'b1;
      end
    end
  end

  always_comb begin
    logic [31:0] base_val;
    logic [31:0] span;
    base_val = 32'h0000_0000;
    span = 32'h0000_0000;
    state_nxt = state_r;
    // Result strobes are one-cycle pulses
    state_nxt.mem.req = 1'b0;
    state_nxt.wr.valid = 1'b0;
    state_nxt.done = 1'b0;
    state_nxt.pc_load = 1'b0;
    state_nxt.status_load = 1'b0;
    state_nxt.saved_load = 1'b0;
    state_nxt.undef = 1'b0;
    case (state_r.phase)
      ST_IDLE: begin
        if (instr_valid && (is_stack_fmt || is_multi_fmt)) begin
          span = {24'h00_0000, count, 2'h0};
          state_nxt.pending = rlist;
          state_nxt.with_extra = is_stack_fmt && ex_bit;
          state_nxt.extra_done = 1'b0;
          state_nxt.is_load = ld_bit;
          state_nxt.is_stack = is_stack_fmt;
          state_nxt.base_idx = instr[stack_branch_pkg::OP_BASE_LSB +: 3];
          state_nxt.base_hit = base_listed;
          base_val = is_stack_fmt ? stack_ptr : low_regs[instr[stack_branch_pkg::OP_BASE_LSB +: 3]];
          if (is_stack_fmt && !ld_bit) begin
            // Full descending: block sits just below the pointer
            state_nxt.addr = base_val - span;
            state_nxt.final_base = base_val - span;
          end else begin
            // Increment-after from the base
            state_nxt.addr = base_val;
            state_nxt.final_base = base_val + span;
          end
          state_nxt.phase = ST_XFER;
        end else if (instr_valid && is_cond_fmt) begin
          if (cond_code == stack_branch_pkg::COND_SOFT_INT) begin
            // Soft interrupt: link, saved status, vector, wide state, supervisor
            state_nxt.wr.valid = 1'b1;
            state_nxt.wr.index = 4'hE;
            state_nxt.wr.data = instr_addr + stack_branch_pkg::HALFWORD_BYTES;
            state_nxt.saved_load = 1'b1;
            state_nxt.saved_value = current_status_word;
            state_nxt.status_load = 1'b1;
            state_nxt.status_value = {current_status_word[31:8], 1'b1, current_status_word[6], 1'b0,
                stack_branch_pkg::MODE_SUPERVISOR};
            state_nxt.pc_load = 1'b1;
            state_nxt.pc_value = stack_branch_pkg::SOFT_INT_VECTOR;
            state_nxt.refill = stack_branch_pkg::REFILL_CYCLES;
            state_nxt.phase = ST_REFILL;
          end else if (cond_code == stack_branch_pkg::COND_UNDEFINED) begin
            // Reserved encoding is flagged rather than executed
            state_nxt.undef = 1'b1;
            state_nxt.phase = ST_FINISH;
          end else if (cond_pass) begin
            // Target from instruction address plus prefetch
            state_nxt.pc_load = 1'b1;
            state_nxt.pc_value = instr_addr + stack_branch_pkg::PREFETCH_BYTES + branch_disp;
            state_nxt.refill = stack_branch_pkg::REFILL_CYCLES;
            state_nxt.phase = ST_REFILL;
          end else begin
            state_nxt.phase = ST_FINISH;
          end
        end
      end
      ST_XFER: begin
        if (has_first) begin
          // One stored word per cycle; a loaded word takes two cycles with the ST_LOAD_WAIT step
          state_nxt.mem.req = 1'b1;
          state_nxt.mem.write = !state_r.is_load;
          state_nxt.mem.addr = state_r.addr;
          state_nxt.mem.wdata = low_regs[first_idx];
          state_nxt.pending[first_idx] = 1'b0;
          state_nxt.load_dst = {1'b0, first_idx};
          state_nxt.addr = state_r.addr + stack_branch_pkg::WORD_BYTES;
          if (state_r.is_load) begin
            state_nxt.phase = ST_LOAD_WAIT;
          end
        end else if (state_r.with_extra && !state_r.extra_done) begin
          // Link on push, program counter on pop, always the highest address
          state_nxt.mem.req = 1'b1;
          state_nxt.mem.write = !state_r.is_load;
          state_nxt.mem.addr = state_r.addr;
          state_nxt.mem.wdata = return_link_register;
          state_nxt.load_dst = 4'hF;
          state_nxt.extra_done = 1'b1;
          state_nxt.addr = state_r.addr + stack_branch_pkg::WORD_BYTES;
          if (state_r.is_load) begin
            state_nxt.phase = ST_LOAD_WAIT;
          end
        end else begin
          state_nxt.phase = ST_WRITEBACK;
        end
      end
      ST_LOAD_WAIT: begin
        if (state_r.load_dst == 4'hF) begin
          // Popped PC causes a branch, bit 0 dropped for halfword fetch
          state_nxt.pc_load = 1'b1;
          state_nxt.pc_value = {mem_rdata[31:1], 1'b0};
        end else begin
          state_nxt.wr.valid = 1'b1;
          state_nxt.wr.index = state_r.load_dst;
          state_nxt.wr.data = mem_rdata;
        end
        state_nxt.phase = ST_XFER;
      end
      ST_WRITEBACK: begin
        // A loaded base keeps the loaded value instead of the written-back one
        state_nxt.wr.valid = state_r.is_stack || !state_r.is_load || !state_r.base_hit;
        state_nxt.wr.index = state_r.is_stack ? 4'hD : {1'b0, state_r.base_idx};
        state_nxt.wr.data = state_r.final_base;
        if (state_r.is_load && state_r.with_extra) begin
          state_nxt.refill = stack_branch_pkg::REFILL_CYCLES;
          state_nxt.phase = ST_REFILL;
        end else begin
          state_nxt.phase = ST_FINISH;
        end
      end
      ST_REFILL: begin
        // Pipeline refill after a taken branch
        state_nxt.refill = state_r.refill - 2'h1;
        if (state_r.refill == 2'h1) begin
          state_nxt.phase = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_nxt.done = 1'b1;
        state_nxt.phase = ST_IDLE;
      end
      default: begin
        state_nxt.phase = ST_IDLE;
      end
    endcase
    if (rst) begin
      state_nxt = '0;
      state_nxt.phase = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    state_r <= state_nxt;
  end

  assign mem_req = state_r.mem;
  assign reg_wr = state_r.wr;
  assign busy = (state_r.phase != ST_IDLE);
  assign done = state_r.done;
  assign pc_load = state_r.pc_load;
  assign pc_value = state_r.pc_value;
  assign status_load = state_r.status_load;
  assign status_value = state_r.status_value;
  assign saved_status_load = state_r.saved_load;
  assign saved_status_value = state_r.saved_value;
  assign undefined_instr = state_r.undef;

endmodule
`default_nettype wire

// [verification/stack_branch_exec_props.sv]
/*
  Checker for the compact stack, block-transfer and branch executor.
  Assumes it is bound to the executor and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module stack_branch_exec_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] current_status_word,
  input wire stack_branch_pkg::mem_req_t mem_req,
  input wire stack_branch_pkg::reg_wr_t reg_wr,
  input wire logic busy,
  input wire logic done,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  input wire logic status_load,
  input wire logic [31:0] status_value,
  input wire logic saved_status_load,
  input wire logic undefined_instr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc;
  // Taken only while idle; the format filter sits in each property
  assign acc = instr_valid && !busy;
  property p_eq_taken;
    acc && instr[15:8] == 8'hD0 && current_status_word[30] |=> pc_load &&
      pc_value == $past(instr_addr) + 32'h0000_0004 + {{23{$past(instr[7])}}, $past(instr[7:0]), 1'b0};
  endproperty
  a_eq_taken: assert property (p_eq_taken) else $error("branch target wrong");
  property p_ne_skip;
    acc && instr[15:8] == 8'hD0 && !current_status_word[30] |=> !pc_load ##1 (done && !pc_load);
  endproperty
  a_ne_skip: assert property (p_ne_skip) else $error("untaken branch misbehaved");
  property p_undef;
    acc && instr[15:8] == 8'hDE |-> ##[1:2] undefined_instr;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code not flagged");
  property p_swi;
    acc && instr[15:8] == 8'hDF |=> pc_load && pc_value == stack_branch_pkg::SOFT_INT_VECTOR;
  endproperty
  a_swi: assert property (p_swi) else $error("soft interrupt vector wrong");
  property p_mode;
    status_load |-> saved_status_load && status_value[4:0] == stack_branch_pkg::MODE_SUPERVISOR && !status_value[5];
  endproperty
  a_mode: assert property (p_mode) else $error("soft interrupt status wrong");
  property p_step;
    mem_req.req && mem_req.write ##1 mem_req.req && mem_req.write |-> mem_req.addr == $past(mem_req.addr) + 32'h4;
  endproperty
  a_step: assert property (p_step) else $error("store addresses not ascending words");
  property p_index;
    reg_wr.valid |-> reg_wr.index <= 4'h7 || reg_wr.index == 4'hD || reg_wr.index == 4'hE;
  endproperty
  a_index: assert property (p_index) else $error("write to illegal register");
  property p_pulse;
    done |=> !done && !busy;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done not a single pulse");
  property p_busy;
    acc && instr[15:12] == 4'hB && instr[10:9] == 2'h2 |=> busy ##[1:40] done;
  endproperty
  a_busy: assert property (p_busy) else $error("stack transfer did not finish");
  // Main scenarios
  c_push: cover property (acc && instr[15:8] == 8'hB5);
  c_pop_pc: cover property (acc && instr[15:8] == 8'hBD);
  c_multi: cover property (acc && instr[15:12] == 4'hC);
  c_swi: cover property (status_load);
endmodule
bind stack_branch_exec stack_branch_exec_props i_stack_branch_exec_props (.core_clk, .rst, .instr_valid, .instr,
  .instr_addr, .current_status_word, .mem_req, .reg_wr, .busy, .done, .pc_load, .pc_value, .status_load,
  .status_value, .saved_status_load, .undefined_instr);
`default_nettype wire

// [verification/mem_model.sv]
/*
  Word memory standing behind the executor's memory port.
  Assumes byte addresses below 0x100; read data stand only while the read request stands.
*/
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  // Clock
  input wire logic core_clk,
  // Memory port
  input wire stack_branch_pkg::mem_req_t mem_req,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [64];
  logic [31:0] rd_word;
  // Plain always so the bench may preload words directly
  always @(posedge core_clk) begin
    if (mem_req.req && mem_req.write) begin
      mem[mem_req.addr[7:2]] <= mem_req.wdata;
    end
  end
  // The executor takes load data in the cycle its registered read request stands
  assign rd_word = mem[mem_req.addr[7:2]];
  // Outside a read the bus shows a wrong value, never a stale one
  assign mem_rdata = (mem_req.req && !mem_req.write) ? rd_word : ~rd_word;
endmodule
`default_nettype wire

// [verification/compact_isa_stack_block_branch_tb.sv]
/*
  Self-checking bench for the compact stack, block-transfer and branch executor.
  Assumes the bench plays the register file and fetch; mem_model plays memory.
*/
`timescale 1ns/1ns
`default_nettype none
module compact_isa_stack_block_branch_tb;
  logic core_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, pc_hit, und_hit;
  logic [15:0] instr = 16'h0000;
  logic [31:0] instr_addr = 32'h0, sp = 32'h0, lnk = 32'h0, stw = 32'h0, mem_rdata, pc_value;
  logic [31:0] lo [8];
  logic [31:0] wr [16];
  logic [31:0] status_value, saved_status_value;
  stack_branch_pkg::mem_req_t mem_req;
  stack_branch_pkg::reg_wr_t reg_wr;
  logic busy, done, pc_load, status_load, saved_status_load, undefined_instr;
  int error_cnt = 0, n_tests = 0, ncyc;
  stack_branch_exec i_stack_branch_exec (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_addr(instr_addr), .low_regs(lo), .stack_ptr(sp), .return_link_register(lnk),
    .current_status_word(stw), .mem_req(mem_req), .mem_rdata(mem_rdata), .reg_wr(reg_wr), .busy(busy),
    .done(done), .pc_load(pc_load), .pc_value(pc_value), .status_load(status_load), .status_value(status_value),
    .saved_status_load(saved_status_load), .saved_status_value(saved_status_value),
    .undefined_instr(undefined_instr));
  mem_model i_mem_model (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (reg_wr.valid === 1'b1) wr[reg_wr.index] <= reg_wr.data;
    if (pc_load === 1'b1) pc_hit <= 1'b1;
    if (undefined_instr === 1'b1) und_hit <= 1'b1;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Offers one instruction and waits for done; ncyc counts edges from take to done
  task automatic issue(logic [15:0] op, logic [31:0] a);
    logic hit;
    hit = 1'b0;
    pc_hit = 1'b0;
    und_hit = 1'b0;
    foreach (wr[i]) wr[i] = 'x;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= op;
    instr_addr <= a;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    for (ncyc = 1; ncyc < 50 && !hit; ncyc++) begin
      @(posedge core_clk);
      #1;
      hit = (done === 1'b1);
    end
    if (!hit) begin
      error_cnt++;
      $display("unexpected done timeout");
      summarize();
    end
  endtask
  task automatic t_push();
    sp <= 32'h100;
    lnk <= 32'h5A5A_0001;
    issue(16'hB501, 32'h200);
    chk("push r0", i_mem_model.mem[62], lo[0]);
    chk("push link", i_mem_model.mem[63], lnk);
    chk("push sp", wr[13], 32'hF8);
    chk("push cycles", ncyc, 6);
    issue(16'hB406, 32'h202);
    chk("push r1", i_mem_model.mem[62], lo[1]);
    chk("push r2", i_mem_model.mem[63], lo[2]);
    chk("push sp2", wr[13], 32'hF8);
  endtask
  task automatic t_pop();
    sp <= 32'hF8;
    i_mem_model.mem[62] = 32'h1111_0000;
    i_mem_model.mem[63] = 32'h0000_0300;
    issue(16'hBD08, 32'h204);
    chk("pop r3", wr[3], 32'h1111_0000);
    chk("pop pc hit", pc_hit, 1'b1);
    chk("pop pc", pc_value, 32'h300);
    chk("pop sp", wr[13], 32'h100);
    issue(16'hBC30, 32'h206);
    chk("pop r4", wr[4], 32'h1111_0000);
    chk("pop r5", wr[5], 32'h300);
    chk("pop sp2", wr[13], 32'h100);
    chk("pop no pc", pc_hit, 1'b0);
  endtask
  task automatic t_multi();
    lo[0] <= 32'h40;
    lo[1] <= 32'h40;
    issue(16'hC006, 32'h208);
    chk("stm w0", i_mem_model.mem[16], 32'h40);
    chk("stm w1", i_mem_model.mem[17], lo[2]);
    chk("stm base", wr[0], 32'h48);
    issue(16'hC90C, 32'h20A);
    chk("ldm r2", wr[2], 32'h40);
    chk("ldm r3", wr[3], lo[2]);
    chk("ldm base", wr[1], 32'h48);
    // Base in its own list: the loaded word must survive, not the written-back address
    issue(16'hC906, 32'h20C);
    chk("ldm r2 hit", wr[2], lo[2]);
    chk("ldm base kept", wr[1], 32'h40);
  endtask
  // Codes 0000-1101 against every flag combination; even codes at offset 0x7F, odd codes at 0x80
  task automatic t_branch();
    logic n, z, c, v, tk;
    logic [7:0] off;
    for (int cc = 0; cc < 14; cc++) begin
      for (int f = 0; f < 16; f++) begin
        {n, z, c, v} = f[3:0];
        off = cc[0] ? 8'h80 : 8'h7F;
        stw <= {f[3:0], 28'h000_0030};
        case (cc)
          0, 1: tk = z;
          2, 3: tk = c;
          4, 5: tk = n;
          6, 7: tk = v;
          8, 9: tk = c && !z;
          10, 11: tk = n == v;
          default: tk = !z && n == v;
        endcase
        tk = tk ^ cc[0];
        issue({4'hD, cc[3:0], off}, 32'h1000);
        chk("branch taken", pc_hit, tk);
        if (tk) chk("branch target", pc_value, 32'h1004 + {{23{off[7]}}, off, 1'b0});
        chk("branch cycles", ncyc, tk ? 4 : 2);
      end
    end
  endtask
  task automatic t_special();
    // Code 1110 is offered only here, to see it refused as a branch
    issue(16'hDE05, 32'h2000);
    chk("undef flag", und_hit, 1'b1);
    chk("undef no pc", pc_hit, 1'b0);
    stw <= 32'h0000_0030;
    issue(16'hDF12, 32'h2000);
    chk("swi pc", pc_value, 32'h8);
    chk("swi link", wr[14], 32'h2002);
    chk("swi saved", saved_status_value, 32'h30);
    chk("swi status", status_value, 32'h93);
    chk("swi cycles", ncyc, 4);
  endtask
  initial begin
    foreach (lo[i]) lo[i] = 32'hA0 + i;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_push();
    t_pop();
    t_multi();
    t_branch();
    t_special();
    summarize();
  end
endmodule
`default_nettype wire
